// >>> inc/ddrca_pkg.sv
// Shared constants and types for the command and address decode block.
`default_nettype none
package ddrca_pkg;
  // Widths of the command and address inputs.
  localparam int ADDR_W = 14;
  localparam int ROW_W = 18;
  localparam int COL_W = 10;
  localparam int BG_W = 2;
  localparam int BA_W = 2;
  localparam int SID_W = 3;
  localparam int BANK_IDX_W = 5;
  localparam int NBANK = 32;
  // Field positions inside the address.
  localparam int AP_POS = 10;
  localparam int BC_POS = 12;
  localparam int TOP_POS = 17;
  // Configuration bit positions.
  localparam int CFG_W = 4;
  localparam int CFG_X4 = 0;
  localparam int CFG_X16 = 1;
  localparam int CFG_STACK = 2;
  localparam int CFG_DDP = 3;
  // Status level positions crossing to the system clock.
  localparam int LVL_W = 7;
  localparam int LVL_CLK_EN = 0;
  localparam int LVL_PPD = 1;
  localparam int LVL_APD = 2;
  localparam int LVL_SREF = 3;
  localparam int LVL_TERM = 4;
  localparam int LVL_DIE1 = 5;
  localparam int LVL_WAKE = 6;
  // Non-activation codes on the three multiplexed lines.
  localparam logic [2:0] CODE_MRS = 3'h0;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_WR = 3'h4;
  localparam logic [2:0] CODE_RD = 3'h5;
  localparam logic [2:0] CODE_ZQ = 3'h6;
  // Reset values of the sampled pins.
  localparam logic RST_SEL_N = 1'h1;
  localparam logic RST_CKE = 1'h0;
  localparam logic [2:0] RST_CODE = 3'h7;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_RD = 4'h2,
    CMD_WR = 4'h3,
    CMD_PRE = 4'h4,
    CMD_REF = 4'h5,
    CMD_MRS = 4'h6,
    CMD_ZQ = 4'h7
  } ddrca_cmd_t;
  typedef enum logic [1:0] {
    PS_ACTIVE = 2'b00,
    PS_PPD = 2'b01,
    PS_APD = 2'b10,
    PS_SREF = 2'b11
  } ddrca_pwr_t;
endpackage
`default_nettype wire

// >>> rtl/ddrca_decode.sv
// Command, address and power state decode of a registered memory module.
`default_nettype none
module ddrca_decode (
  // System clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Configuration, system clock domain.
  input wire logic cfg_x4_i,
  input wire logic cfg_x16_i,
  input wire logic cfg_stacked_i,
  input wire logic cfg_dual_die_i,
  // Link clock pair.
  input wire logic true_clock_input_i,
  input wire logic complement_clock_input_i,
  // Link control inputs.
  input wire logic rank_select_low_i,
  input wire logic second_rank_select_low_i,
  input wire logic clock_gate_input_i,
  input wire logic second_clock_gate_i,
  input wire logic termination_control_i,
  input wire logic second_termination_control_i,
  // Link command and address inputs.
  input wire logic activate_strobe_low_i,
  input wire logic row_strobe_or_addr16_i,
  input wire logic column_strobe_or_addr15_i,
  input wire logic write_strobe_or_addr14_i,
  input wire logic [ddrca_pkg::ADDR_W-1:0] addr_i,
  input wire logic top_address_bit_i,
  input wire logic [ddrca_pkg::BG_W-1:0] bank_group_select_i,
  input wire logic [ddrca_pkg::BA_W-1:0] bank_select_i,
  input wire logic [ddrca_pkg::SID_W-1:0] stack_die_id_i,
  // Decoded command, system clock domain.
  output logic cmd_valid_o,
  output logic [3:0] cmd_code_o,
  output logic cmd_die_o,
  output logic [ddrca_pkg::SID_W-1:0] cmd_stack_o,
  output logic [ddrca_pkg::BG_W-1:0] cmd_group_o,
  output logic [ddrca_pkg::BA_W-1:0] cmd_bank_o,
  output logic [ddrca_pkg::ROW_W-1:0] cmd_row_o,
  output logic [ddrca_pkg::COL_W-1:0] cmd_col_o,
  output logic cmd_auto_pre_o,
  output logic cmd_full_burst_o,
  output logic [ddrca_pkg::NBANK-1:0] banks_open_o,
  // Power and termination state, system clock domain.
  output logic clocks_enabled_o,
  output logic precharge_pd_o,
  output logic active_pd_o,
  output logic self_refresh_o,
  output logic termination_on_o,
  output logic second_die_enabled_o,
  output logic self_refresh_wake_o
);
  import ddrca_pkg::*;

  function automatic logic [NBANK-1:0] die_mask(input logic die);
    logic [NBANK-1:0] m;
    m = '0;
    for (int i = 0; i < NBANK; i++) begin
      m[i] = (i >= NBANK / 2) == die;
    end
    return m;
  endfunction

  // ==========================================================================
  // Link reset and configuration crossing
  // ==========================================================================
  logic [1:0] lrst_ff;
  logic link_rst_b;
  logic [CFG_W-1:0] cfg_s1_ff, cfg_s2_ff;

  // Assertion is immediate; release is retimed to the link clock.
  always_ff @(posedge true_clock_input_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lrst_ff <= 2'h0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'h1};
    end
  end
  assign link_rst_b = lrst_ff[1];

  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cfg_s1_ff <= '0;
      cfg_s2_ff <= '0;
    end else begin
      cfg_s1_ff <= {cfg_dual_die_i, cfg_stacked_i, cfg_x16_i, cfg_x4_i};
      cfg_s2_ff <= cfg_s1_ff;
    end
  end

  // ==========================================================================
  // Pin sampling
  // ==========================================================================
  ddrca_pwr_t pwr_ff, nxt_pwr;
  logic in_sr, in_pd;
  logic cke_ff, cke_prev_ff, second_clock_gate_ff, ckc_ff, odt_ff, second_termination_control_ff, smp_ok_ff;
  logic cs_ff, cs1_ff, act_ff, a17_ff;
  logic [2:0] code_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [BG_W-1:0] bg_ff;
  logic [BA_W-1:0] ba_ff;
  logic [SID_W-1:0] sid_ff;

  assign in_sr = pwr_ff == PS_SREF;
  assign in_pd = (pwr_ff == PS_PPD) || (pwr_ff == PS_APD);

  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cke_ff <= RST_CKE;
      cke_prev_ff <= RST_CKE;
      second_clock_gate_ff <= RST_CKE;
      ckc_ff <= 1'h0;
      smp_ok_ff <= 1'h0;
    end else begin
      cke_ff <= clock_gate_input_i;
      cke_prev_ff <= cke_ff;
      second_clock_gate_ff <= second_clock_gate_i;
      ckc_ff <= complement_clock_input_i;
      // Pins frozen at low-power entry must not be replayed as a command on exit.
      smp_ok_ff <= !in_sr && !in_pd;
    end
  end

  // Termination stays live in power-down, not in self refresh.
  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      odt_ff <= 1'h0;
      second_termination_control_ff <= 1'h0;
    end else if (!in_sr) begin
      odt_ff <= termination_control_i;
      second_termination_control_ff <= second_termination_control_i;
    end
  end

  // Command and address buffers are off in both low-power states.
  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cs_ff <= RST_SEL_N;
      cs1_ff <= RST_SEL_N;
      act_ff <= RST_SEL_N;
      code_ff <= RST_CODE;
      addr_ff <= '0;
      a17_ff <= 1'h0;
      bg_ff <= '0;
      ba_ff <= '0;
      sid_ff <= '0;
    end else if (!in_sr && !in_pd) begin
      cs_ff <= rank_select_low_i;
      cs1_ff <= second_rank_select_low_i;
      act_ff <= activate_strobe_low_i;
      code_ff <= {row_strobe_or_addr16_i, column_strobe_or_addr15_i, write_strobe_or_addr14_i};
      addr_ff <= addr_i;
      a17_ff <= top_address_bit_i;
      bg_ff <= bank_group_select_i;
      ba_ff <= bank_select_i;
      sid_ff <= stack_die_id_i;
    end
  end

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic sel0, sel1, selected, cross_ok, nxt_die, gate_ok, sre;
  ddrca_cmd_t cmd;
  logic [ROW_W-1:0] nxt_row;
  logic [BG_W-1:0] nxt_bg;
  logic [SID_W-1:0] nxt_sid;
  logic [BANK_IDX_W-1:0] bank_idx;
  logic [ROW_W-1:0] mem_row;

  assign sel0 = !cs_ff;
  assign sel1 = cfg_s2_ff[CFG_DDP] && !cs1_ff;
  assign selected = sel0 || sel1;
  assign nxt_die = sel1 && !sel0;
  // A command counts only when the complement was low at the true rising edge.
  assign cross_ok = !ckc_ff;
  assign gate_ok = nxt_die ? second_clock_gate_ff : cke_ff;
  assign nxt_row = {cfg_s2_ff[CFG_X4] & a17_ff, code_ff, addr_ff};
  assign nxt_bg = cfg_s2_ff[CFG_X16] ? {1'h0, bg_ff[0]} : bg_ff;
  assign nxt_sid = (cfg_s2_ff[CFG_STACK] && !cfg_s2_ff[CFG_X16]) ? sid_ff : '0;
  assign bank_idx = {nxt_die, nxt_bg, ba_ff};
  assign sre = (pwr_ff == PS_ACTIVE) && selected && cross_ok && act_ff && (code_ff == CODE_REF)
    && cke_prev_ff && !cke_ff;

  always_comb begin
    cmd = CMD_NOP;
    if (selected && cross_ok && gate_ok && smp_ok_ff && pwr_ff == PS_ACTIVE) begin
      if (!act_ff) begin
        cmd = CMD_ACT;
      end else begin
        case (code_ff)
          CODE_MRS: cmd = CMD_MRS;
          CODE_REF: cmd = CMD_REF;
          CODE_PRE: cmd = CMD_PRE;
          CODE_WR: cmd = CMD_WR;
          CODE_RD: cmd = CMD_RD;
          CODE_ZQ: cmd = CMD_ZQ;
          default: cmd = CMD_NOP;
        endcase
      end
    end
  end

  ddrca_row_mem u_row_mem (
    .clk_i(true_clock_input_i),
    .rst_b_i(link_rst_b),
    .wr_en_i(cmd == CMD_ACT),
    .wr_addr_i(bank_idx),
    .wr_data_i(nxt_row),
    .rd_addr_i(bank_idx),
    .rd_data_o(mem_row)
  );

  // ==========================================================================
  // Bank state
  // ==========================================================================
  logic [NBANK-1:0] open_ff, nxt_open;

  // Auto-precharge marks the bank closed at the access itself, so no later
  // command can be decoded against a row that is about to close.
  always_comb begin
    nxt_open = open_ff;
    case (cmd)
      CMD_ACT: nxt_open[bank_idx] = 1'h1;
      CMD_PRE: begin
        if (addr_ff[AP_POS]) begin
          nxt_open = open_ff & ~die_mask(nxt_die);
        end else begin
          nxt_open[bank_idx] = 1'h0;
        end
      end
      CMD_RD, CMD_WR: begin
        if (addr_ff[AP_POS]) begin
          nxt_open[bank_idx] = 1'h0;
        end
      end
      default: nxt_open = open_ff;
    endcase
  end

  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      open_ff <= '0;
    end else begin
      open_ff <= nxt_open;
    end
  end

  // ==========================================================================
  // Event pipeline and packet
  // ==========================================================================
  logic ev_valid_ff, ev_die_ff, ev_ap_ff, ev_bc_ff;
  ddrca_cmd_t ev_cmd_ff;
  logic [SID_W-1:0] ev_sid_ff;
  logic [BG_W-1:0] ev_bg_ff;
  logic [BA_W-1:0] ev_ba_ff;
  logic [ROW_W-1:0] ev_row_ff;
  logic [COL_W-1:0] ev_col_ff;
  logic pk_tgl_ff, pk_die_ff, pk_ap_ff, pk_bc_ff;
  ddrca_cmd_t pk_cmd_ff;
  logic [SID_W-1:0] pk_sid_ff;
  logic [BG_W-1:0] pk_bg_ff;
  logic [BA_W-1:0] pk_ba_ff;
  logic [ROW_W-1:0] pk_row_ff;
  logic [COL_W-1:0] pk_col_ff;
  logic [NBANK-1:0] pk_open_ff;

  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      ev_valid_ff <= 1'h0;
      ev_cmd_ff <= CMD_NOP;
      ev_die_ff <= 1'h0;
      ev_sid_ff <= '0;
      ev_bg_ff <= '0;
      ev_ba_ff <= '0;
      ev_row_ff <= '0;
      ev_col_ff <= '0;
      ev_ap_ff <= 1'h0;
      ev_bc_ff <= 1'h0;
    end else begin
      ev_valid_ff <= cmd != CMD_NOP;
      ev_cmd_ff <= cmd;
      ev_die_ff <= nxt_die;
      ev_sid_ff <= nxt_sid;
      ev_bg_ff <= nxt_bg;
      ev_ba_ff <= ba_ff;
      ev_row_ff <= nxt_row;
      ev_col_ff <= addr_ff[COL_W-1:0];
      ev_ap_ff <= addr_ff[AP_POS];
      ev_bc_ff <= addr_ff[BC_POS];
    end
  end

  // The packet holds until the next command, which the system side reads
  // long before the link clock can deliver another one.
  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      pk_tgl_ff <= 1'h0;
      pk_cmd_ff <= CMD_NOP;
      pk_die_ff <= 1'h0;
      pk_sid_ff <= '0;
      pk_bg_ff <= '0;
      pk_ba_ff <= '0;
      pk_row_ff <= '0;
      pk_col_ff <= '0;
      pk_ap_ff <= 1'h0;
      pk_bc_ff <= 1'h0;
      pk_open_ff <= '0;
    end else if (ev_valid_ff) begin
      pk_tgl_ff <= !pk_tgl_ff;
      pk_cmd_ff <= ev_cmd_ff;
      pk_die_ff <= ev_die_ff;
      pk_sid_ff <= ev_sid_ff;
      pk_bg_ff <= ev_bg_ff;
      pk_ba_ff <= ev_ba_ff;
      pk_row_ff <= (ev_cmd_ff == CMD_RD || ev_cmd_ff == CMD_WR) ? mem_row : ev_row_ff;
      pk_col_ff <= ev_col_ff;
      pk_ap_ff <= ev_ap_ff;
      pk_bc_ff <= ev_bc_ff;
      pk_open_ff <= open_ff;
    end
  end

  // ==========================================================================
  // Power state and self refresh wake
  // ==========================================================================
  logic sr_arm_ff, wake_ff, wake_s1_ff, wake_s2_ff, wake_rst_b;
  logic [LVL_W-2:0] lvl_ff;

  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PS_ACTIVE: begin
        if (cke_prev_ff && !cke_ff) begin
          nxt_pwr = sre ? PS_SREF : ((open_ff == '0) ? PS_PPD : PS_APD);
        end
      end
      PS_PPD, PS_APD: begin
        if (cke_ff) begin
          nxt_pwr = PS_ACTIVE;
        end
      end
      PS_SREF: begin
        if (wake_s2_ff) begin
          nxt_pwr = PS_ACTIVE;
        end
      end
      default: nxt_pwr = PS_ACTIVE;
    endcase
  end

  always_ff @(posedge true_clock_input_i or negedge link_rst_b) begin
    if (!link_rst_b) begin
      pwr_ff <= PS_ACTIVE;
      sr_arm_ff <= 1'h0;
      wake_s1_ff <= 1'h0;
      wake_s2_ff <= 1'h0;
      lvl_ff <= '0;
    end else begin
      pwr_ff <= nxt_pwr;
      sr_arm_ff <= nxt_pwr == PS_SREF;
      wake_s1_ff <= wake_ff;
      wake_s2_ff <= wake_s1_ff;
      lvl_ff[LVL_CLK_EN] <= cke_ff;
      lvl_ff[LVL_PPD] <= nxt_pwr == PS_PPD;
      lvl_ff[LVL_APD] <= nxt_pwr == PS_APD;
      lvl_ff[LVL_SREF] <= nxt_pwr == PS_SREF;
      lvl_ff[LVL_TERM] <= odt_ff || (cfg_s2_ff[CFG_DDP] && second_termination_control_ff);
      lvl_ff[LVL_DIE1] <= cfg_s2_ff[CFG_DDP] && second_clock_gate_ff;
    end
  end

  // The gate pin itself clocks this flag, so the exit is caught even while
  // the link clock is stopped; it is cleared once self refresh is left.
  assign wake_rst_b = rst_b_i && sr_arm_ff;
  always_ff @(posedge clock_gate_input_i or negedge wake_rst_b) begin
    if (!wake_rst_b) begin
      wake_ff <= 1'h0;
    end else begin
      wake_ff <= 1'h1;
    end
  end

  // ==========================================================================
  // System clock side
  // ==========================================================================
  logic [LVL_W-1:0] lvl_src, lvl_sync;
  logic tg_s1_ff, tg_s2_ff, tg_s3_ff, cmd_valid_ff, cmd_die_ff, cmd_ap_ff, cmd_bc_ff;
  logic [3:0] cmd_code_ff;
  logic [SID_W-1:0] cmd_sid_ff;
  logic [BG_W-1:0] cmd_bg_ff;
  logic [BA_W-1:0] cmd_ba_ff;
  logic [ROW_W-1:0] cmd_row_ff;
  logic [COL_W-1:0] cmd_col_ff;
  logic [NBANK-1:0] cmd_open_ff;

  assign lvl_src = {wake_ff, lvl_ff};

  for (genvar i = 0; i < LVL_W; i++) begin : g_lvl
    logic s1_ff, s2_ff;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        s1_ff <= 1'h0;
        s2_ff <= 1'h0;
      end else begin
        s1_ff <= lvl_src[i];
        s2_ff <= s1_ff;
      end
    end
    assign lvl_sync[i] = s2_ff;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tg_s1_ff <= 1'h0;
      tg_s2_ff <= 1'h0;
      tg_s3_ff <= 1'h0;
      cmd_valid_ff <= 1'h0;
    end else begin
      tg_s1_ff <= pk_tgl_ff;
      tg_s2_ff <= tg_s1_ff;
      tg_s3_ff <= tg_s2_ff;
      cmd_valid_ff <= tg_s2_ff != tg_s3_ff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_code_ff <= CMD_NOP;
      cmd_die_ff <= 1'h0;
      cmd_sid_ff <= '0;
      cmd_bg_ff <= '0;
      cmd_ba_ff <= '0;
      cmd_row_ff <= '0;
      cmd_col_ff <= '0;
      cmd_ap_ff <= 1'h0;
      cmd_bc_ff <= 1'h0;
      cmd_open_ff <= '0;
    end else if (tg_s2_ff != tg_s3_ff) begin
      cmd_code_ff <= pk_cmd_ff;
      cmd_die_ff <= pk_die_ff;
      cmd_sid_ff <= pk_sid_ff;
      cmd_bg_ff <= pk_bg_ff;
      cmd_ba_ff <= pk_ba_ff;
      cmd_row_ff <= pk_row_ff;
      cmd_col_ff <= pk_col_ff;
      cmd_ap_ff <= pk_ap_ff;
      cmd_bc_ff <= pk_bc_ff;
      cmd_open_ff <= pk_open_ff;
    end
  end

  assign cmd_valid_o = cmd_valid_ff;
  assign cmd_code_o = cmd_code_ff;
  assign cmd_die_o = cmd_die_ff;
  assign cmd_stack_o = cmd_sid_ff;
  assign cmd_group_o = cmd_bg_ff;
  assign cmd_bank_o = cmd_ba_ff;
  assign cmd_row_o = cmd_row_ff;
  assign cmd_col_o = cmd_col_ff;
  assign cmd_auto_pre_o = cmd_ap_ff;
  assign cmd_full_burst_o = cmd_bc_ff;
  assign banks_open_o = cmd_open_ff;
  assign clocks_enabled_o = lvl_sync[LVL_CLK_EN];
  assign precharge_pd_o = lvl_sync[LVL_PPD];
  assign active_pd_o = lvl_sync[LVL_APD];
  assign self_refresh_o = lvl_sync[LVL_SREF];
  assign termination_on_o = lvl_sync[LVL_TERM];
  assign second_die_enabled_o = lvl_sync[LVL_DIE1];
  assign self_refresh_wake_o = lvl_sync[LVL_WAKE];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_cke_fall;
    pwr_ff == PS_ACTIVE && cke_prev_ff && !cke_ff;
  endsequence

  a_deselect_ignored: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    !selected |=> !ev_valid_ff ##1 $stable(pk_tgl_ff)) else $error("Deselected command produced an event.");
  a_act_opens_bank: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    cmd == CMD_ACT |=> open_ff[$past(bank_idx)] && ev_row_ff[16:14] == $past(code_ff))
    else $error("Activate did not open its bank.");
  a_pre_all_banks: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    (cmd == CMD_PRE && addr_ff[AP_POS]) |=> (open_ff & die_mask($past(nxt_die))) == '0)
    else $error("Precharge all left a bank open.");
  a_access_autopre: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    ((cmd == CMD_RD || cmd == CMD_WR) && addr_ff[AP_POS]) |=> !open_ff[$past(bank_idx)])
    else $error("Auto-precharge did not close the bank.");
  a_ppd_entry: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    (s_cke_fall ##0 (!sre && open_ff == '0)) |=> pwr_ff == PS_PPD) else $error("Precharge power-down missed.");
  a_apd_entry: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    (s_cke_fall ##0 (!sre && open_ff != '0)) |=> pwr_ff == PS_APD) else $error("Active power-down missed.");
  a_sref_masks: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    in_sr |=> $stable(cs_ff) && $stable(odt_ff) && $stable(addr_ff)) else $error("Input sampled in self refresh.");
  a_pd_masks: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    in_pd |=> $stable(act_ff) && $stable(code_ff) && cmd == CMD_NOP) else $error("Command accepted in power-down.");
  a_group_x16: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    (ev_valid_ff && $past(cfg_s2_ff[CFG_X16])) |-> !ev_bg_ff[1]) else $error("Upper group bit used for x16.");
  a_top_bit_x4: assert property (@(posedge true_clock_input_i) disable iff (!link_rst_b)
    (cmd == CMD_ACT && !cfg_s2_ff[CFG_X4]) |-> ##2 !pk_row_ff[TOP_POS]) else $error("Top address bit not ignored.");
  a_event_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (tg_s2_ff != tg_s3_ff) |=> cmd_valid_ff && cmd_row_ff == $past(pk_row_ff) ##1 !cmd_valid_ff)
    else $error("Command packet not captured.");
endmodule
`default_nettype wire

// >>> rtl/ddrca_row_mem.sv
// Open-row memory, one entry per die, bank group and bank, with registered read.
`default_nettype none
module ddrca_row_mem #(
  parameter int DEPTH = ddrca_pkg::NBANK,
  parameter int AW = ddrca_pkg::BANK_IDX_W,
  parameter int DW = ddrca_pkg::ROW_W
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // Read port.
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  import ddrca_pkg::*;
  logic [DW-1:0] mem_ff [DEPTH];
  logic [DW-1:0] rd_data_ff;

  // A read of the entry being written returns the old row; timing between
  // activation and access makes that case unreachable.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem_ff[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_ff;
endmodule
`default_nettype wire

// >>> verification/ddr4_command_address_decode_tb.sv
// Self-checking bench for the command and address decode block.
`default_nettype none
module ddr4_command_address_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ddrca_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic termination_control = 1'b0;
  logic cfg_x4 = 1'b1;
  logic cfg_x16 = 1'b0;
  logic ck, ck_n, cs_n, cke, cv, ap, fb, ppd, ce, ton;
  logic apd, sr, wk, die, s2e;
  logic [1:0] grp;
  logic [2:0] stk;
  logic [22:0] c;
  logic [3:0] cc;
  logic [1:0] ba;
  logic [9:0] col;
  logic [17:0] row;
  logic [31:0] bo;
  int n_checks = 0;
  int bad_count = 0;
  ddrca_ctrl_model ctl (.ck_o(ck), .ck_n_o(ck_n), .cs_n_o(cs_n), .cke_o(cke), .cmd_o(c));
  ddrca_decode dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_x4_i(cfg_x4), .cfg_x16_i(cfg_x16), .cfg_stacked_i(1'b0),
    .cfg_dual_die_i(1'b0), .true_clock_input_i(ck), .complement_clock_input_i(ck_n), .rank_select_low_i(cs_n),
    .second_rank_select_low_i(1'b1), .clock_gate_input_i(cke), .second_clock_gate_i(cke),
    .termination_control_i(termination_control), .second_termination_control_i(termination_control), .activate_strobe_low_i(c[22]),
    .row_strobe_or_addr16_i(c[21]), .column_strobe_or_addr15_i(c[20]), .write_strobe_or_addr14_i(c[19]),
    .addr_i(c[13:0]), .top_address_bit_i(c[14]), .bank_group_select_i(c[18:17]), .bank_select_i(c[16:15]),
    .stack_die_id_i(c[2:0]), .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_die_o(die), .cmd_stack_o(stk), .cmd_group_o(grp),
    .cmd_bank_o(ba), .cmd_row_o(row), .cmd_col_o(col), .cmd_auto_pre_o(ap), .cmd_full_burst_o(fb),
    .banks_open_o(bo), .clocks_enabled_o(ce), .precharge_pd_o(ppd), .active_pd_o(apd), .self_refresh_o(sr),
    .termination_on_o(ton), .second_die_enabled_o(s2e), .self_refresh_wake_o(wk)
  );
  always #12.5 sys_clk_i = ~sys_clk_i;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A selected command must show up within the bound; a deselected one is only waited for, not checked here.
  task automatic issue(input logic sel_n, input logic [22:0] cmd);
    int i;
    ctl.send(sel_n, cmd);
    for (i = 0; i < 40 && cv !== 1'b1; i++) @(negedge sys_clk_i);
    if (sel_n === 1'b0 && cv !== 1'b1) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic t_access();
    issue(1'b0, {1'b0, 3'h5, 2'h2, 2'h1, 1'b1, 14'h1abc});
    chk(cc, CMD_ACT);
    chk(row, {1'b1, 3'h5, 14'h1abc});
    chk(bo, 32'h200);
    chk(stk, 3'h0);
    issue(1'b0, {1'b1, CODE_RD, 2'h2, 2'h1, 1'b0, 14'h0555});
    chk(cc, CMD_RD);
    chk(row, {1'b1, 3'h5, 14'h1abc});
    chk(col, 10'h155);
    chk(ap, 1'b1);
    chk(fb, 1'b0);
    chk(bo, 32'h0);
  endtask
  task automatic t_pre();
    issue(1'b0, {1'b0, 3'h0, 2'h2, 2'h1, 1'b0, 14'h0});
    issue(1'b0, {1'b0, 3'h0, 2'h0, 2'h0, 1'b0, 14'h0});
    issue(1'b0, {1'b1, CODE_WR, 2'h2, 2'h1, 1'b0, 14'h1000});
    chk(cc, CMD_WR);
    chk(fb, 1'b1);
    chk(bo, 32'h201);
    issue(1'b0, {1'b1, CODE_PRE, 2'h2, 2'h1, 1'b0, 14'h0});
    chk(bo, 32'h1);
    issue(1'b0, {1'b1, CODE_PRE, 2'h0, 2'h0, 1'b0, 14'h0400});
    chk(bo, 32'h0);
  endtask
  task automatic t_sel_mrs();
    issue(1'b1, {1'b0, 3'h0, 2'h3, 2'h3, 1'b0, 14'h0});
    chk(cv, 1'b0);
    issue(1'b0, {1'b1, CODE_MRS, 2'h1, 2'h2, 1'b1, 14'h0123});
    chk(cc, CMD_MRS);
    chk(row, 18'h20123);
    chk(ba, 2'h2);
    chk(die, 1'b0);
    chk(bo, 32'h0);
  endtask
  task automatic t_power();
    termination_control = 1'b1;
    ctl.gate(1'b0);
    repeat (20) @(negedge sys_clk_i);
    chk(ppd, 1'b1);
    chk(ce, 1'b0);
    chk(ton, 1'b1);
    chk(s2e, 1'b0);
    ctl.gate(1'b1);
    repeat (20) @(negedge sys_clk_i);
    chk(ppd, 1'b0);
    chk(ce, 1'b1);
  endtask
  // Refresh with the gate falling at the same edge enters self refresh; the gate rise wakes it.
  task automatic t_sref();
    fork
      ctl.send(1'b0, {1'b1, CODE_REF, 2'h0, 2'h0, 1'b0, 14'h0});
      ctl.gate(1'b0);
    join
    repeat (20) @(negedge sys_clk_i);
    chk(sr, 1'b1);
    chk(ppd, 1'b0);
    ctl.gate(1'b1);
    repeat (6) @(negedge sys_clk_i);
    chk(wk, 1'b1);
    repeat (20) @(negedge sys_clk_i);
    chk(sr, 1'b0);
    chk(wk, 1'b0);
  endtask
  // x16 component with x4 off: top bit and upper group bit ignored; open bank gives active power-down.
  task automatic t_cfg();
    cfg_x4 = 1'b0;
    cfg_x16 = 1'b1;
    repeat (30) @(negedge sys_clk_i);
    issue(1'b0, {1'b0, 3'h2, 2'h3, 2'h1, 1'b1, 14'h0007});
    chk(row, {1'b0, 3'h2, 14'h0007});
    chk(grp, 2'h1);
    chk(bo, 32'h20);
    ctl.gate(1'b0);
    repeat (20) @(negedge sys_clk_i);
    chk(apd, 1'b1);
    chk(ppd, 1'b0);
    ctl.gate(1'b1);
    repeat (20) @(negedge sys_clk_i);
    chk(apd, 1'b0);
    issue(1'b0, {1'b1, CODE_PRE, 2'h0, 2'h0, 1'b0, 14'h0400});
    chk(cc, CMD_PRE);
    chk(bo, 32'h0);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    t_access();
    t_pre();
    t_sel_mrs();
    t_power();
    t_sref();
    t_cfg();
    end_sim();
  end
endmodule
`default_nettype wire

// >>> verification/ddrca_ctrl_model.sv
// Memory controller model driving the link clock and command pins.
`default_nettype none
module ddrca_ctrl_model (
  // Link clock pair.
  output logic ck_o,
  output logic ck_n_o,
  // Select, clock gate and packed {activate, code, group, bank, top bit, address}.
  output logic cs_n_o,
  output logic cke_o,
  output logic [22:0] cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // The complement moves first in each time step, so the true edge always sees a settled crossing.
  initial begin
    ck_o = 1'b0;
    ck_n_o = 1'b1;
    cs_n_o = 1'b1;
    cke_o = 1'b1;
    cmd_o = 23'h7fffff;
    #7;
    forever begin
      #62.5;
      ck_n_o = ck_o;
      ck_o = ~ck_o;
    end
  end
  // Released lines show the inverse so a stale value is never mistaken for a command.
  task automatic send(input logic cs_n, input logic [22:0] cmd);
    @(negedge ck_o);
    cs_n_o = cs_n;
    cmd_o = cmd;
    @(negedge ck_o);
    cs_n_o = 1'b1;
    cmd_o = ~cmd;
  endtask
  // The gate moves at a falling link clock edge, the same edge at which send drives a command.
  task automatic gate(input logic v);
    @(negedge ck_o);
    cke_o = v;
  endtask
endmodule
`default_nettype wire
